/* File: hdl/dtio_top.sv */
// Functional notes
// - Start level at run start selects idling speed search.
// - Forced stop off decelerates over forced-stop time.
// - Halt after forced stop enters forced-stop alarm.
// - Keypad select makes run and frequency source local.
// - Dew heating drives DC current while halted and idle.
// - Run-source switch picks parameter, secondary or command word pair.
// - Secondary inputs run; release decelerates to stop.
// - Primary forward runs forward; release stops.
// - Primary backward runs reverse; release stops.
// - Primary run codes only on the two run terminals.
// - Code plus 1000 inverts the selected signal.
// - Factory reset gives normal polarity.
// - Normal polarity alarm energizes relay.
// - Inverted polarity alarm de-energizes relay.
// - Line contactor codes 11-13 have no inverted form.
// - Codes 0, 1, 2, 3, 5, 6, 7, 10 select basic status.
// - Codes 15, 25-28, 30, 33, 35-37 select warnings.
// - Codes 42-45, 54-56, 59, 60 select loop and motor status.
// - Three transistor and two relay outputs.
// - Running sets above start, clears below stop or braking.
// - Arrival within 2.5 Hz of reference.
// - Detect above level, clears below level minus 1 Hz.
// - Limiting held at least 100 ms.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`include "dtio_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dtio_top
  import dtio_pkg::*;
#(
  parameter int unsigned LIMIT_HOLD_CYCLES = `DTIO_LIMIT_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Input terminals
  input  wire logic        START_SPEED_SEARCH,
  input  wire logic        FORCED_STOP_OK,
  input  wire logic        KEYPAD_SOURCE_SELECT,
  input  wire logic        DEW_HEATING,
  input  wire logic        RUN_SOURCE_SWITCH,
  input  wire logic        SECONDARY_FORWARD,
  input  wire logic        SECONDARY_BACKWARD,
  input  wire logic        RUN_TERMINAL_A,
  input  wire logic        RUN_TERMINAL_B,
  input  wire logic        KEYPAD_FORWARD,
  input  wire logic        KEYPAD_BACKWARD,
  // Drive state
  input  wire logic [15:0] OUT_FREQ,
  input  wire logic [15:0] REF_FREQ,
  input  wire logic        DC_BRAKING,
  input  wire logic        MOTOR_HALTED,
  input  wire logic [24:0] STATUS_FLAGS,
  // Commands to motor control
  output logic             RUN_FORWARD_CMD,
  output logic             RUN_BACKWARD_CMD,
  output logic             FORCED_DECEL_CMD,
  output logic      [15:0] FORCED_DECEL_TIME,
  output logic             SPEED_SEARCH_CMD,
  output logic             DC_HEAT_CMD,
  output logic             LOCAL_MODE,
  output logic             FORCED_STOP_ALARM,
  // Programmable output terminals
  output logic             TRANSISTOR_OUT_1,
  output logic             TRANSISTOR_OUT_2,
  output logic             TRANSISTOR_OUT_3,
  output logic             RELAY_OUT,
  output logic             ALARM_RELAY
);

  // ========================================================================
  // Reset release
  logic       rst_meta_reg;
  logic       rst_n_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ========================================================================
  // Registers
  logic [3:0]  ctrl_reg;
  logic [10:0] out_assign_reg [5];
  logic [10:0] in_assign_a_reg;
  logic [10:0] in_assign_b_reg;
  logic [15:0] fstop_time_reg;
  logic [3:0]  comm_word_reg;
  logic [15:0] start_freq_reg;
  logic [15:0] stop_freq_reg;
  logic [15:0] detect_level_reg;
  logic        alarm_clr;
  logic [31:0] status_word;

  assign alarm_clr = WR && (ADDR == `DTIO_OFS_CTRL) && WDATA[`DTIO_CTRL_ALARM_CLR];

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg         <= `DTIO_RST_CTRL;
      in_assign_a_reg  <= `DTIO_RST_IN_ASSIGN_A;
      in_assign_b_reg  <= `DTIO_RST_IN_ASSIGN_B;
      fstop_time_reg   <= `DTIO_RST_FSTOP_TIME;
      comm_word_reg    <= 4'h0;
      start_freq_reg   <= `DTIO_RST_START_FREQ;
      stop_freq_reg    <= `DTIO_RST_STOP_FREQ;
      detect_level_reg <= `DTIO_RST_DETECT_LEVEL;
    end else if (WR) begin
      case (ADDR)
        `DTIO_OFS_CTRL:         ctrl_reg         <= {1'b0, WDATA[2:0]};
        `DTIO_OFS_IN_ASSIGN_A:  in_assign_a_reg  <= WDATA[10:0];
        `DTIO_OFS_IN_ASSIGN_B:  in_assign_b_reg  <= WDATA[10:0];
        `DTIO_OFS_FSTOP_TIME:   fstop_time_reg   <= WDATA[15:0];
        `DTIO_OFS_COMM_WORD:    comm_word_reg    <= WDATA[3:0];
        `DTIO_OFS_START_FREQ:   start_freq_reg   <= WDATA[15:0];
        `DTIO_OFS_STOP_FREQ:    stop_freq_reg    <= WDATA[15:0];
        `DTIO_OFS_DETECT_LEVEL: detect_level_reg <= WDATA[15:0];
        default: ;
      endcase
    end
  end

  // Factory default: normal polarity
  generate
    for (genvar i = 0; i < 5; i++) begin : g_assign
      always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          out_assign_reg[i] <= (i == 4) ? `DTIO_CODE_ALARM : 11'(i);
        end else if (WR && ADDR == (`DTIO_OFS_OUT_ASSIGN0 + 8'(4 * i))) begin
          out_assign_reg[i] <= WDATA[10:0];
        end
      end
    end
  endgenerate

  // ========================================================================
  // Run source selection
  logic      prim_fwd;
  logic      prim_rev;
  logic      want_fwd;
  logic      want_rev;
  dtio_src_t src;

  // Only the two run terminals decode the primary run codes
  assign prim_fwd = (RUN_TERMINAL_A && in_assign_a_reg == `DTIO_CODE_FWD) ||
                    (RUN_TERMINAL_B && in_assign_b_reg == `DTIO_CODE_FWD);
  assign prim_rev = (RUN_TERMINAL_A && in_assign_a_reg == `DTIO_CODE_REV) ||
                    (RUN_TERMINAL_B && in_assign_b_reg == `DTIO_CODE_REV);

  always_comb begin
    if (KEYPAD_SOURCE_SELECT) begin
      src = DTIO_SRC_KEYPAD;
    end else if (ctrl_reg[`DTIO_CTRL_LINK_EN]) begin
      src = DTIO_SRC_COMM;
    end else if (RUN_SOURCE_SWITCH) begin
      src = DTIO_SRC_SECOND;
    end else if (ctrl_reg[`DTIO_CTRL_SRC_TERM]) begin
      src = DTIO_SRC_PRIMARY;
    end else begin
      src = DTIO_SRC_KEYPAD;
    end
  end

  always_comb begin
    case (src)
      DTIO_SRC_PRIMARY: begin
        want_fwd = prim_fwd;
        want_rev = prim_rev;
      end
      DTIO_SRC_SECOND: begin
        want_fwd = SECONDARY_FORWARD;
        want_rev = SECONDARY_BACKWARD;
      end
      DTIO_SRC_COMM: begin
        want_fwd = RUN_SOURCE_SWITCH ? comm_word_reg[`DTIO_CW_SECONDARY_FORWARD] : comm_word_reg[`DTIO_CW_FWD];
        want_rev = RUN_SOURCE_SWITCH ? comm_word_reg[`DTIO_CW_SECONDARY_BACKWARD] : comm_word_reg[`DTIO_CW_REV];
      end
      default: begin
        want_fwd = KEYPAD_FORWARD;
        want_rev = KEYPAD_BACKWARD;
      end
    endcase
  end

  // ========================================================================
  // Run and forced-stop sequence
  dtio_state_t state_reg;
  dtio_state_t state_next;
  logic        run_req;

  // Both directions at once means stop
  assign run_req = want_fwd ^ want_rev;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DTIO_IDLE:   if (!FORCED_STOP_OK) state_next = DTIO_FSTOP;
                   else if (run_req)    state_next = DTIO_RUN;
      DTIO_RUN:    if (!FORCED_STOP_OK) state_next = DTIO_FSTOP;
                   else if (!run_req)   state_next = DTIO_IDLE;
      DTIO_FSTOP:  if (MOTOR_HALTED)    state_next = DTIO_FALARM;
      DTIO_FALARM: if (alarm_clr && FORCED_STOP_OK) state_next = DTIO_IDLE;
      default:     state_next = DTIO_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= DTIO_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      RUN_FORWARD_CMD   <= 1'b0;
      RUN_BACKWARD_CMD  <= 1'b0;
      FORCED_DECEL_CMD  <= 1'b0;
      FORCED_DECEL_TIME <= `DTIO_RST_FSTOP_TIME;
      FORCED_STOP_ALARM <= 1'b0;
      LOCAL_MODE        <= 1'b0;
    end else begin
      // Dropping the run command is what makes motor control decelerate
      RUN_FORWARD_CMD   <= (state_next == DTIO_RUN) && want_fwd;
      RUN_BACKWARD_CMD  <= (state_next == DTIO_RUN) && want_rev;
      FORCED_DECEL_CMD  <= (state_next == DTIO_FSTOP);
      FORCED_DECEL_TIME <= fstop_time_reg;
      FORCED_STOP_ALARM <= (state_next == DTIO_FALARM);
      LOCAL_MODE        <= KEYPAD_SOURCE_SELECT;
    end
  end

  // Start level caught on entry to run, held for the run
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      SPEED_SEARCH_CMD <= 1'b0;
    end else if (state_reg != DTIO_RUN && state_next == DTIO_RUN) begin
      SPEED_SEARCH_CMD <= START_SPEED_SEARCH;
    end else if (state_next != DTIO_RUN) begin
      SPEED_SEARCH_CMD <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      DC_HEAT_CMD <= 1'b0;
    end else begin
      DC_HEAT_CMD <= DEW_HEATING && MOTOR_HALTED && (state_next == DTIO_IDLE);
    end
  end

  // ========================================================================
  // Derived status signals
  logic        running_reg;
  logic        arrival_reg;
  logic        detect_reg;
  logic        limit_reg;
  logic [23:0] limit_cnt_reg;
  logic [15:0] freq_diff;
  logic [15:0] detect_low;

  assign freq_diff  = (OUT_FREQ > REF_FREQ) ? OUT_FREQ - REF_FREQ : REF_FREQ - OUT_FREQ;
  assign detect_low = (detect_level_reg > `DTIO_DETECT_HYST) ? detect_level_reg - `DTIO_DETECT_HYST : 16'h0000;

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      running_reg <= 1'b0;
    end else if (DC_BRAKING || OUT_FREQ < stop_freq_reg) begin
      running_reg <= 1'b0;
    end else if (OUT_FREQ > start_freq_reg) begin
      running_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      arrival_reg <= 1'b0;
    end else begin
      arrival_reg <= (freq_diff <= `DTIO_ARRIVAL_BAND);
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      detect_reg <= 1'b0;
    end else if (OUT_FREQ > detect_level_reg) begin
      detect_reg <= 1'b1;
    end else if (OUT_FREQ < detect_low) begin
      detect_reg <= 1'b0;
    end
  end

  // Each new assertion restarts the hold so short bursts still read as one pulse
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      limit_reg     <= 1'b0;
      limit_cnt_reg <= 24'h000000;
    end else if (STATUS_FLAGS[`DTIO_F_LIMIT_RAW]) begin
      limit_reg     <= 1'b1;
      limit_cnt_reg <= 24'(LIMIT_HOLD_CYCLES - 1);
    end else if (limit_cnt_reg != 24'h000000) begin
      limit_cnt_reg <= limit_cnt_reg - 24'h000001;
    end else begin
      limit_reg     <= 1'b0;
    end
  end

  // ========================================================================
  // Output selectors
  logic [63:0] sig;
  logic [4:0]  out_level;

  always_comb begin
    sig       = 64'h0;
    sig[0]    = running_reg;
    sig[1]    = arrival_reg;
    sig[2]    = detect_reg;
    sig[3]    = STATUS_FLAGS[`DTIO_F_UNDERVOLT];
    sig[5]    = limit_reg;
    sig[6]    = STATUS_FLAGS[`DTIO_F_POWER_DIP];
    sig[7]    = STATUS_FLAGS[`DTIO_F_OVERLOAD_WARN];
    sig[10]   = STATUS_FLAGS[`DTIO_F_READY];
    sig[11]   = STATUS_FLAGS[`DTIO_F_LINE_CONT_1];
    sig[12]   = STATUS_FLAGS[`DTIO_F_LINE_CONT_2];
    sig[13]   = STATUS_FLAGS[`DTIO_F_LINE_CONT_3];
    sig[15]   = STATUS_FLAGS[`DTIO_F_MAINS_CONT];
    sig[25]   = STATUS_FLAGS[`DTIO_F_FAN];
    sig[26]   = STATUS_FLAGS[`DTIO_F_AUTO_RESET];
    sig[27]   = ctrl_reg[`DTIO_CTRL_UNIV_OUT];
    sig[28]   = STATUS_FLAGS[`DTIO_F_HEATSINK_HOT];
    sig[30]   = STATUS_FLAGS[`DTIO_F_LIFE];
    sig[33]   = STATUS_FLAGS[`DTIO_F_CMD_LOSS];
    sig[35]   = STATUS_FLAGS[`DTIO_F_OUTPUT_ON];
    sig[36]   = STATUS_FLAGS[`DTIO_F_OVERLOAD_PREV];
    sig[37]   = STATUS_FLAGS[`DTIO_F_CURRENT_DET];
    sig[42]   = STATUS_FLAGS[`DTIO_F_LOOP_ALARM];
    sig[43]   = STATUS_FLAGS[`DTIO_F_LOOP_CTL];
    sig[44]   = STATUS_FLAGS[`DTIO_F_LOOP_SLOW];
    sig[45]   = STATUS_FLAGS[`DTIO_F_LOW_TORQUE];
    sig[54]   = !KEYPAD_SOURCE_SELECT;
    sig[55]   = run_req;
    sig[56]   = STATUS_FLAGS[`DTIO_F_PTC_HOT];
    sig[59]   = STATUS_FLAGS[`DTIO_F_AIN_OFF];
    sig[60]   = STATUS_FLAGS[`DTIO_F_MOTOR1_INV];
  end

  // Supported active-high codes except line contactor 11-13, plus the any-alarm code
  function automatic logic code_known(input logic [10:0] c);
    case (c)
      11'd0, 11'd1, 11'd2, 11'd3, 11'd5, 11'd6, 11'd7, 11'd10,
      11'd15, 11'd25, 11'd26, 11'd27, 11'd28, 11'd30, 11'd33,
      11'd35, 11'd36, 11'd37, 11'd42, 11'd43, 11'd44, 11'd45,
      11'd54, 11'd55, 11'd56, 11'd59, 11'd60, 11'd99: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction

  generate
    for (genvar i = 0; i < 5; i++) begin : g_out
      logic        inv;
      logic [10:0] base;
      logic        valid;
      logic        sel;
      assign inv   = out_assign_reg[i] >= `DTIO_CODE_INV_OFS;
      assign base  = inv ? out_assign_reg[i] - `DTIO_CODE_INV_OFS : out_assign_reg[i];
      // Line contactor codes have no inverted form
      assign valid = code_known(base) ||
                     (!inv && base >= 11'd11 && base <= 11'd13);
      assign sel   = (base == `DTIO_CODE_ALARM) ? (STATUS_FLAGS[`DTIO_F_ALARM] || FORCED_STOP_ALARM)
                                                : sig[base[5:0]];
      assign out_level[i] = valid && (sel ^ inv);
    end
  endgenerate

  // High energizes a relay coil
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      TRANSISTOR_OUT_1 <= 1'b0;
      TRANSISTOR_OUT_2 <= 1'b0;
      TRANSISTOR_OUT_3 <= 1'b0;
      RELAY_OUT        <= 1'b0;
      ALARM_RELAY      <= 1'b0;
    end else begin
      TRANSISTOR_OUT_1 <= out_level[0];
      TRANSISTOR_OUT_2 <= out_level[1];
      TRANSISTOR_OUT_3 <= out_level[2];
      RELAY_OUT        <= out_level[3];
      ALARM_RELAY      <= out_level[4];
    end
  end

  // ========================================================================
  // Read port
  assign status_word = {21'h0, limit_reg, detect_reg, arrival_reg, running_reg,
                        LOCAL_MODE, DC_HEAT_CMD, SPEED_SEARCH_CMD, 1'b0, state_reg};

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        `DTIO_OFS_CTRL:         RDATA <= {28'h0, ctrl_reg};
        `DTIO_OFS_IN_ASSIGN_A:  RDATA <= {21'h0, in_assign_a_reg};
        `DTIO_OFS_IN_ASSIGN_B:  RDATA <= {21'h0, in_assign_b_reg};
        `DTIO_OFS_FSTOP_TIME:   RDATA <= {16'h0, fstop_time_reg};
        `DTIO_OFS_COMM_WORD:    RDATA <= {28'h0, comm_word_reg};
        `DTIO_OFS_STATUS:       RDATA <= status_word;
        `DTIO_OFS_START_FREQ:   RDATA <= {16'h0, start_freq_reg};
        `DTIO_OFS_STOP_FREQ:    RDATA <= {16'h0, stop_freq_reg};
        `DTIO_OFS_DETECT_LEVEL: RDATA <= {16'h0, detect_level_reg};
        8'h04, 8'h08, 8'h0C, 8'h10, 8'h14:
                                RDATA <= {21'h0, out_assign_reg[ADDR[4:2] - 3'd1]};
        default:                RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/dtio_defines.svh */
`ifndef DTIO_DEFINES_SVH
`define DTIO_DEFINES_SVH

// ==========================================================================
// Register map (byte addresses)
`define DTIO_OFS_CTRL         8'h00
`define DTIO_OFS_OUT_ASSIGN0  8'h04
`define DTIO_OFS_OUT_ASSIGN4  8'h14
`define DTIO_OFS_IN_ASSIGN_A  8'h18
`define DTIO_OFS_IN_ASSIGN_B  8'h1C
`define DTIO_OFS_FSTOP_TIME   8'h20
`define DTIO_OFS_COMM_WORD    8'h24
`define DTIO_OFS_STATUS       8'h28
`define DTIO_OFS_START_FREQ   8'h2C
`define DTIO_OFS_STOP_FREQ    8'h30
`define DTIO_OFS_DETECT_LEVEL 8'h34

// ==========================================================================
// Control and command word fields
`define DTIO_CTRL_LINK_EN     0
`define DTIO_CTRL_SRC_TERM    1
`define DTIO_CTRL_UNIV_OUT    2
`define DTIO_CTRL_ALARM_CLR   3
`define DTIO_CW_FWD           0
`define DTIO_CW_REV           1
`define DTIO_CW_SECONDARY_FORWARD          2
`define DTIO_CW_SECONDARY_BACKWARD          3

// ==========================================================================
// Reset values
`define DTIO_RST_CTRL         4'h0
`define DTIO_RST_FSTOP_TIME   16'h0014
`define DTIO_RST_START_FREQ   16'h0005
`define DTIO_RST_STOP_FREQ    16'h0002
`define DTIO_RST_DETECT_LEVEL 16'h0258
`define DTIO_RST_IN_ASSIGN_A  11'h062
`define DTIO_RST_IN_ASSIGN_B  11'h063

// ==========================================================================
// Function codes
`define DTIO_CODE_INV_OFS     11'h3E8
`define DTIO_CODE_FWD         11'h062
`define DTIO_CODE_REV         11'h063
`define DTIO_CODE_ALARM       11'h063

// ==========================================================================
// Frequency units are 0.1 Hz
`define DTIO_ARRIVAL_BAND     16'h0019
`define DTIO_DETECT_HYST      16'h000A

// ==========================================================================
// Timing
`define DTIO_CLK_HZ           25000000
`define DTIO_LIMIT_MIN_MS     100
`define DTIO_LIMIT_CYCLES     ((`DTIO_CLK_HZ / 1000) * `DTIO_LIMIT_MIN_MS)

// ==========================================================================
// Status flag input bit positions
`define DTIO_F_UNDERVOLT      0
`define DTIO_F_POWER_DIP      1
`define DTIO_F_OVERLOAD_WARN  2
`define DTIO_F_READY          3
`define DTIO_F_LINE_CONT_1    4
`define DTIO_F_LINE_CONT_2    5
`define DTIO_F_LINE_CONT_3    6
`define DTIO_F_MAINS_CONT     7
`define DTIO_F_FAN            8
`define DTIO_F_AUTO_RESET     9
`define DTIO_F_HEATSINK_HOT   10
`define DTIO_F_LIFE           11
`define DTIO_F_CMD_LOSS       12
`define DTIO_F_OUTPUT_ON      13
`define DTIO_F_OVERLOAD_PREV  14
`define DTIO_F_CURRENT_DET    15
`define DTIO_F_LOOP_ALARM     16
`define DTIO_F_LOOP_CTL       17
`define DTIO_F_LOOP_SLOW      18
`define DTIO_F_LOW_TORQUE     19
`define DTIO_F_PTC_HOT        20
`define DTIO_F_AIN_OFF        21
`define DTIO_F_MOTOR1_INV     22
`define DTIO_F_ALARM          23
`define DTIO_F_LIMIT_RAW      24
`define DTIO_NFLAGS           25

`endif

/* File: hdl/dtio_pkg.sv */
package dtio_pkg;

  typedef enum logic [1:0] {
    DTIO_IDLE    = 2'b00,
    DTIO_RUN     = 2'b01,
    DTIO_FSTOP   = 2'b10,
    DTIO_FALARM  = 2'b11
  } dtio_state_t;

  typedef enum logic [1:0] {
    DTIO_SRC_KEYPAD   = 2'b00,
    DTIO_SRC_PRIMARY  = 2'b01,
    DTIO_SRC_SECOND   = 2'b10,
    DTIO_SRC_COMM     = 2'b11
  } dtio_src_t;

endpackage

/* File: testbench/dtio_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ============
// Port-level checks
module dtio_top_chk (
  // Bus
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Terminals
  input wire logic        START_SPEED_SEARCH,
  input wire logic        FORCED_STOP_OK,
  input wire logic        DEW_HEATING,
  input wire logic        MOTOR_HALTED,
  input wire logic        RUN_FORWARD_CMD,
  input wire logic        RUN_BACKWARD_CMD,
  input wire logic        FORCED_DECEL_CMD,
  input wire logic [15:0] FORCED_DECEL_TIME,
  input wire logic        SPEED_SEARCH_CMD,
  input wire logic        DC_HEAT_CMD,
  input wire logic        FORCED_STOP_ALARM
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire idle = !RUN_FORWARD_CMD && !RUN_BACKWARD_CMD;

  a_stop_cuts_run: assert property (!FORCED_STOP_OK |=> idle)
    else $error("run during stop");
  a_halt_alarm: assert property (FORCED_DECEL_CMD && MOTOR_HALTED |=> FORCED_STOP_ALARM && !FORCED_DECEL_CMD)
    else $error("no halt alarm");
  a_alarm_hold: assert property (FORCED_STOP_ALARM && !(WR && ADDR == 8'h00 && WDATA[3]) |=> FORCED_STOP_ALARM)
    else $error("alarm dropped");
  a_dir_exclusive: assert property (!(RUN_FORWARD_CMD && RUN_BACKWARD_CMD))
    else $error("both directions");
  a_search_capture: assert property ($past(idle) && RUN_FORWARD_CMD |-> SPEED_SEARCH_CMD == $past(START_SPEED_SEARCH))
    else $error("search level lost");
  a_decel_write: assert property (WR && ADDR == 8'h20 |=> ##1 FORCED_DECEL_TIME == $past(WDATA[15:0], 2))
    else $error("decel time lost");
  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("stray read data");
  a_dew_off: assert property (!DEW_HEATING |=> !DC_HEAT_CMD)
    else $error("stray heating");

  c_alarm: cover property ($rose(FORCED_STOP_ALARM));
  c_search: cover property (RUN_FORWARD_CMD && SPEED_SEARCH_CMD);
  c_heat: cover property (DC_HEAT_CMD);
endmodule

bind dtio_top dtio_top_chk u_dtio_top_chk (.CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .START_SPEED_SEARCH,
  .FORCED_STOP_OK, .DEW_HEATING, .MOTOR_HALTED, .RUN_FORWARD_CMD, .RUN_BACKWARD_CMD, .FORCED_DECEL_CMD,
  .FORCED_DECEL_TIME, .SPEED_SEARCH_CMD, .DC_HEAT_CMD, .FORCED_STOP_ALARM);
`default_nettype wire

/* File: testbench/dtio_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============
// Far-side motor: halts DECEL cycles after the last run command
module dtio_motor_model #(
  parameter int DECEL = 6
) (
  input wire logic CLK,
  input wire logic RUN_FORWARD_CMD,
  input wire logic RUN_BACKWARD_CMD,
  output logic     MOTOR_HALTED
);
  int spin = 0;
  always @(posedge CLK) begin
    if (RUN_FORWARD_CMD || RUN_BACKWARD_CMD) spin <= DECEL;
    else if (spin > 0) spin <= spin - 1;
  end
  assign MOTOR_HALTED = (spin == 0);
endmodule
`default_nettype wire

/* File: testbench/test_dtio_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dtio_top;
  logic        CLK = 1'b0;
  logic        ARST_N, WR, RD, START_SPEED_SEARCH, FORCED_STOP_OK, KEYPAD_SOURCE_SELECT, DEW_HEATING;
  logic        RUN_SOURCE_SWITCH, SECONDARY_FORWARD, SECONDARY_BACKWARD, RUN_TERMINAL_A, RUN_TERMINAL_B;
  logic        KEYPAD_FORWARD, KEYPAD_BACKWARD, DC_BRAKING;
  logic [7:0]  ADDR;
  logic [31:0] WDATA;
  logic [15:0] OUT_FREQ, REF_FREQ;
  logic [24:0] STATUS_FLAGS;
  wire  [31:0] RDATA;
  wire  [15:0] FORCED_DECEL_TIME;
  wire         MOTOR_HALTED, RUN_FORWARD_CMD, RUN_BACKWARD_CMD, FORCED_DECEL_CMD, SPEED_SEARCH_CMD, DC_HEAT_CMD;
  wire         LOCAL_MODE, FORCED_STOP_ALARM, TRANSISTOR_OUT_1, TRANSISTOR_OUT_2, TRANSISTOR_OUT_3, RELAY_OUT;
  wire         ALARM_RELAY;
  wire  [4:0]  outs = {ALARM_RELAY, RELAY_OUT, TRANSISTOR_OUT_3, TRANSISTOR_OUT_2, TRANSISTOR_OUT_1};
  wire  [1:0]  dir  = {RUN_FORWARD_CMD, RUN_BACKWARD_CMD};
  int          checks = 0;
  int          fail_count = 0;
  // code[k] selects status flag bit k
  int code[23] = '{3, 6, 7, 10, 11, 12, 13, 15, 25, 26, 28, 30, 33, 35, 36, 37, 42, 43, 44, 45, 56, 59, 60};
  int rc[8] = '{0, 0, 0, 2, 2, 2, 1, 1};
  int rf[8] = '{10, 3, 1, 601, 595, 589, 80, 70};
  int rx[8] = '{1, 1, 0, 1, 1, 0, 1, 0};

  dtio_top #(.LIMIT_HOLD_CYCLES(16)) u_dtio_top (.CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .START_SPEED_SEARCH, .FORCED_STOP_OK, .KEYPAD_SOURCE_SELECT, .DEW_HEATING, .RUN_SOURCE_SWITCH,
    .SECONDARY_FORWARD, .SECONDARY_BACKWARD, .RUN_TERMINAL_A, .RUN_TERMINAL_B, .KEYPAD_FORWARD,
    .KEYPAD_BACKWARD, .OUT_FREQ, .REF_FREQ, .DC_BRAKING, .MOTOR_HALTED, .STATUS_FLAGS, .RUN_FORWARD_CMD,
    .RUN_BACKWARD_CMD, .FORCED_DECEL_CMD, .FORCED_DECEL_TIME, .SPEED_SEARCH_CMD, .DC_HEAT_CMD, .LOCAL_MODE,
    .FORCED_STOP_ALARM, .TRANSISTOR_OUT_1, .TRANSISTOR_OUT_2, .TRANSISTOR_OUT_3, .RELAY_OUT, .ALARM_RELAY);
  dtio_motor_model u_dtio_motor_model (.CLK, .RUN_FORWARD_CMD, .RUN_BACKWARD_CMD, .MOTOR_HALTED);

  initial forever #20 CLK = ~CLK;

  // ============
  // Bus and check tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK) WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK) RD <= 1'b0;
    @(negedge CLK) chk("rdata", RDATA, e);
  endtask
  // Sample mid-cycle after n edges
  task automatic look(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ============
  // Tests
  initial begin
    int t;
    {ARST_N, WR, RD, START_SPEED_SEARCH, KEYPAD_SOURCE_SELECT, DEW_HEATING, RUN_SOURCE_SWITCH} = '0;
    {SECONDARY_FORWARD, SECONDARY_BACKWARD, RUN_TERMINAL_A, RUN_TERMINAL_B, KEYPAD_FORWARD} = '0;
    {KEYPAD_BACKWARD, DC_BRAKING, ADDR, WDATA, OUT_FREQ, STATUS_FLAGS} = '0;
    FORCED_STOP_OK = 1'b1;
    REF_FREQ = 16'd100;
    repeat (4) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    rd(8'h18, 32'd98);
    rd(8'h1C, 32'd99);
    rd(8'h20, 32'h14);
    rd(8'hFC, 32'h0);
    rd(8'h14, 32'd99);
    @(posedge CLK) STATUS_FLAGS <= 25'h1 << 23;
    look(3); chk("alarm", ALARM_RELAY, 1);
    wr(8'h14, 32'd1099);
    look(3); chk("alarm_inv", ALARM_RELAY, 0);
    @(posedge CLK) STATUS_FLAGS <= '0;
    look(3); chk("alarm_inv_idle", ALARM_RELAY, 1);
    for (int k = 0; k < 23; k++) begin
      t = k % 5;
      wr(8'h04 + 8'(4 * t), code[k]);
      @(posedge CLK) STATUS_FLAGS <= 25'h1 << k;
      look(3); chk("sel", outs[t], 1);
      wr(8'h04 + 8'(4 * t), code[k] + 1000);
      look(3); chk("inv_on", outs[t], 0);
      @(posedge CLK) STATUS_FLAGS <= '0;
      look(3); chk("inv_off", outs[t], (k >= 4 && k <= 6) ? 0 : 1);
    end
    @(posedge CLK) STATUS_FLAGS <= '1;
    wr(8'h04, 32'd4);
    look(3); chk("unsupported", TRANSISTOR_OUT_1, 0);
    @(posedge CLK) STATUS_FLAGS <= '0;
    for (int k = 0; k < 8; k++) begin
      wr(8'h04, rc[k]);
      @(posedge CLK) OUT_FREQ <= 16'(rf[k]);
      look(4); chk("derived", TRANSISTOR_OUT_1, rx[k]);
    end
    wr(8'h04, 32'd0);
    @(posedge CLK) {OUT_FREQ, DC_BRAKING} <= {16'd10, 1'b1};
    look(4); chk("dc_brake", TRANSISTOR_OUT_1, 0);
    @(posedge CLK) {OUT_FREQ, DC_BRAKING} <= '0;
    wr(8'h04, 32'd5);
    @(posedge CLK) STATUS_FLAGS <= 25'h1 << 24;
    @(posedge CLK) STATUS_FLAGS <= '0;
    look(8); chk("limit_held", TRANSISTOR_OUT_1, 1);
    look(16); chk("limit_end", TRANSISTOR_OUT_1, 0);
    wr(8'h00, 32'h2);
    @(posedge CLK) {START_SPEED_SEARCH, RUN_TERMINAL_A} <= 2'b11;
    look(2); chk("fwd_search", {RUN_FORWARD_CMD, SPEED_SEARCH_CMD}, 2'b11);
    @(posedge CLK) {RUN_TERMINAL_A, RUN_TERMINAL_B} <= 2'b01;
    look(2); chk("rev", dir, 2'b01);
    wr(8'h20, 32'h30);
    @(posedge CLK) FORCED_STOP_OK <= 1'b0;
    look(2); chk("fdecel", {FORCED_DECEL_CMD, RUN_BACKWARD_CMD, FORCED_DECEL_TIME}, {2'b10, 16'h30});
    look(12); chk("falarm", {FORCED_STOP_ALARM, FORCED_DECEL_CMD}, 2'b10);
    @(posedge CLK) {FORCED_STOP_OK, RUN_TERMINAL_B} <= 2'b10;
    wr(8'h00, 32'hA);
    look(2); chk("clear", FORCED_STOP_ALARM, 0);
    wr(8'h18, 32'd99);
    @(posedge CLK) RUN_TERMINAL_A <= 1'b1;
    look(2); chk("a_rev", RUN_BACKWARD_CMD, 1);
    wr(8'h18, 32'd5);
    look(2); chk("a_other", RUN_BACKWARD_CMD, 0);
    @(posedge CLK) {RUN_TERMINAL_A, RUN_SOURCE_SWITCH, SECONDARY_FORWARD} <= 3'b011;
    look(2); chk("sec_fwd", dir, 2'b10);
    @(posedge CLK) {SECONDARY_FORWARD, SECONDARY_BACKWARD} <= 2'b01;
    look(2); chk("sec_rev", dir, 2'b01);
    @(posedge CLK) SECONDARY_BACKWARD <= 1'b0;
    look(2); chk("sec_stop", dir, 2'b00);
    wr(8'h00, 32'h3);
    wr(8'h24, 32'h4);
    look(2); chk("link_secondary_forward", dir, 2'b10);
    @(posedge CLK) RUN_SOURCE_SWITCH <= 1'b0;
    wr(8'h24, 32'h2);
    look(2); chk("link_rev", dir, 2'b01);
    @(posedge CLK) {KEYPAD_SOURCE_SELECT, KEYPAD_FORWARD} <= 2'b11;
    look(2); chk("local", {LOCAL_MODE, dir}, 3'b110);
    wr(8'h24, 32'h0);
    @(posedge CLK) {KEYPAD_SOURCE_SELECT, KEYPAD_FORWARD, DEW_HEATING} <= 3'b001;
    look(12); chk("dew", DC_HEAT_CMD, 1);
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
